// file: adcsq_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 125 MHz aclk, instruction cycle of four oscillator periods
// Notes: Definitions only
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCSQ_OFF_CTRL2 12'h000
`define ADCSQ_OFF_CTRL 12'h004
`define ADCSQ_OFF_RESULT 12'h008
`define ADCSQ_OFF_STATUS 12'h00C
`define ADCSQ_OFF_MASK 12'h010

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ADCSQ_CLKSEL_LSB 0
`define ADCSQ_ACQSEL_LSB 3
`define ADCSQ_EN_BIT 0
`define ADCSQ_GO_BIT 1
`define ADCSQ_IRQ_BIT 0
`define ADCSQ_CTRL2_RST 6'h00
`define ADCSQ_RESULT_W 12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSQ_CLK_NS 8
`define ADCSQ_INSTR_CYCLE_NS 32
`define ADCSQ_INSTR_CYCLE_CLKS ((`ADCSQ_INSTR_CYCLE_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`define ADCSQ_RECOVER_CYCLES 2
`define ADCSQ_CONV_TADS 13

`endif

// file: adcsq_pkg.sv
// Purpose: Types shared by the sequencer modules
// Assumes: Nothing
// Notes: No constants here; see adcsq_params.svh
package adcsq_pkg;
    typedef enum logic [2:0] {
        ADCSQ_OFF,
        ADCSQ_DISCHARGE,
        ADCSQ_SAMPLE,
        ADCSQ_START_WAIT,
        ADCSQ_ACQUIRE,
        ADCSQ_CONVERT,
        ADCSQ_RECOVER
    } adcsq_state_t;
endpackage

// file: adcsq_tad_if.sv
// Purpose: Conversion clock request and tick between sequencer and clock generator
// Assumes: Single aclk domain
// Notes: tick is a one-cycle pulse per conversion clock period
`timescale 1ns/1ps
`default_nettype none
interface adcsq_tad_if;
    logic run;
    logic [2:0] clk_sel;
    logic tick;
    modport ctl (output run, output clk_sel, input tick);
    modport gen (input run, input clk_sel, output tick);
endinterface
`default_nettype wire

// file: adcsq_tad_gen.sv
// Purpose: Conversion clock period generator (divided oscillator or internal RC)
// Assumes: rc_osc_in is asynchronous and much slower than aclk
// Notes: Ticks only while run is high
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
module adcsq_tad_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rc_osc_in,
    adcsq_tad_if.gen tad
);
    logic [2:0] rc_sync;
    logic [5:0] div_cnt;
    logic [3:0] rc_delay;
    logic rc_mode;

    function automatic logic [6:0] clk_div(input logic [2:0] sel);
        unique case (sel)
            3'h0: clk_div = 7'h02;
            3'h4: clk_div = 7'h04;
            3'h1: clk_div = 7'h08;
            3'h5: clk_div = 7'h10;
            3'h2: clk_div = 7'h20;
            3'h6: clk_div = 7'h40;
            default: clk_div = 7'h00;
        endcase
    endfunction

    assign rc_mode = (tad.clk_sel[1:0] == 2'b11);

    // ----------------------------------------------------------------
    // RC source synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync <= 3'h0;
        end else begin
            rc_sync <= {rc_sync[1:0], rc_osc_in};
        end
    end

    // ----------------------------------------------------------------
    // Period generation
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !tad.run) begin
            div_cnt <= 6'h00;
            rc_delay <= 4'h0;
            tad.tick <= 1'b0;
        end else if (rc_mode) begin
            div_cnt <= 6'h00;
            if (rc_delay < 4'(`ADCSQ_INSTR_CYCLE_CLKS)) begin
                rc_delay <= rc_delay + 4'h1;
                tad.tick <= 1'b0;
            end else begin
                tad.tick <= rc_sync[1] & ~rc_sync[2];
            end
        end else if (div_cnt == 6'(clk_div(tad.clk_sel) - 7'h01)) begin
            div_cnt <= 6'h00;
            tad.tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 6'h01;
            tad.tick <= 1'b0;
        end
    end
endmodule // adcsq_tad_gen
`default_nettype wire

// file: adcsq_seq.sv
// Purpose: Acquisition and conversion sequencer for a 12-bit successive-approximation converter
// Assumes: AXI4-Lite master on aclk; comparator and RC oscillator arrive asynchronously
// Notes: Top module; all outputs registered
// Summary of operation
// - Nonzero acquisition field: sample programmed periods, then convert automatically.
// - Acquisition field zero: start bit ends sampling and starts conversion directly.
// - Acquisition field resets to zero, manual mode.
// - Completion clears start bit, sets interrupt flag, resumes sampling.
// - No status separates end of acquisition from start of conversion.
// - A conversion lasts exactly 13 conversion clock periods.
// - Clock select maps codes to 2..64 oscillator periods or RC source.
// - Acquisition code 010 inserts four periods before conversion.
// - Manual mode conversion starts one instruction cycle after the start write.
// - Clearing start bit mid-conversion aborts; result stays unchanged.
// - Two instruction cycles of recovery after completion or abort.
// - Capacitor array is discharged before every sample.
// - Acquisition codes map 2,4,6,8,12,16,20 periods.
// - RC source adds one instruction cycle before its clock runs.
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
module adcsq_seq #(
    parameter int DISCHARGE_CLKS = `ADCSQ_INSTR_CYCLE_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_in,
    input wire logic rc_osc_in,
    output logic sample_en,
    output logic discharge_en,
    output logic [11:0] dac_code,
    output logic irq
);
    localparam logic [3:0] RECOVER_CLKS = 4'(`ADCSQ_RECOVER_CYCLES * `ADCSQ_INSTR_CYCLE_CLKS);
    localparam logic [3:0] WAIT_CLKS = 4'(`ADCSQ_INSTR_CYCLE_CLKS);

    adcsq_pkg::adcsq_state_t state;
    logic [5:0] converter_control_reg_two;
    logic enable;
    logic go_done;
    logic [11:0] result_register_pair;
    logic converter_irq_flag;
    logic irq_mask;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic do_write;
    logic [1:0] comp_sync;
    logic [4:0] tad_cnt;
    logic [3:0] clk_cnt;
    logic [3:0] bit_idx;
    logic done_evt;
    logic abort_evt;
    logic go_set;
    logic go_clr;
    logic [2:0] acq_sel;

    adcsq_tad_if tad_bus ();

    adcsq_tad_gen u_tad_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .rc_osc_in(rc_osc_in),
        .tad(tad_bus)
    );

    function automatic logic [4:0] acq_periods(input logic [2:0] sel);
        unique case (sel)
            3'h0: acq_periods = 5'h00;
            3'h1: acq_periods = 5'h02;
            3'h2: acq_periods = 5'h04;
            3'h3: acq_periods = 5'h06;
            3'h4: acq_periods = 5'h08;
            3'h5: acq_periods = 5'h0C;
            3'h6: acq_periods = 5'h10;
            3'h7: acq_periods = 5'h14;
        endcase
    endfunction

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        reg_hit = (a[11:2] == off[11:2]);
    endfunction

    assign acq_sel = converter_control_reg_two[`ADCSQ_ACQSEL_LSB +: 3];
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign go_set = do_write && reg_hit(aw_addr, `ADCSQ_OFF_CTRL) && w_strb[0]
        && w_data[`ADCSQ_GO_BIT] && w_data[`ADCSQ_EN_BIT] && enable;
    assign go_clr = do_write && reg_hit(aw_addr, `ADCSQ_OFF_CTRL) && w_strb[0]
        && !w_data[`ADCSQ_GO_BIT];
    assign done_evt = (state == adcsq_pkg::ADCSQ_CONVERT) && tad_bus.tick
        && (tad_cnt == 5'(`ADCSQ_CONV_TADS - 1));
    assign abort_evt = go_clr && (state == adcsq_pkg::ADCSQ_CONVERT
        || state == adcsq_pkg::ADCSQ_ACQUIRE || state == adcsq_pkg::ADCSQ_START_WAIT);
    assign tad_bus.run = (state == adcsq_pkg::ADCSQ_ACQUIRE)
        || (state == adcsq_pkg::ADCSQ_CONVERT);
    assign tad_bus.clk_sel = converter_control_reg_two[`ADCSQ_CLKSEL_LSB +: 3];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_hit(aw_addr, `ADCSQ_OFF_CTRL2)
                    || reg_hit(aw_addr, `ADCSQ_OFF_CTRL)
                    || reg_hit(aw_addr, `ADCSQ_OFF_RESULT)
                    || reg_hit(aw_addr, `ADCSQ_OFF_STATUS)
                    || reg_hit(aw_addr, `ADCSQ_OFF_MASK)) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (reg_hit(s_axi_araddr, `ADCSQ_OFF_CTRL2)) begin
                    s_axi_rdata <= {26'h0, converter_control_reg_two};
                end else if (reg_hit(s_axi_araddr, `ADCSQ_OFF_CTRL)) begin
                    s_axi_rdata <= {30'h0, go_done, enable};
                end else if (reg_hit(s_axi_araddr, `ADCSQ_OFF_RESULT)) begin
                    s_axi_rdata <= {20'h0, result_register_pair};
                end else if (reg_hit(s_axi_araddr, `ADCSQ_OFF_STATUS)) begin
                    s_axi_rdata <= {31'h0, converter_irq_flag};
                end else if (reg_hit(s_axi_araddr, `ADCSQ_OFF_MASK)) begin
                    s_axi_rdata <= {31'h0, irq_mask};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_reg_two <= `ADCSQ_CTRL2_RST;
            enable <= 1'b0;
            irq_mask <= 1'b0;
        end else if (do_write && w_strb[0]) begin
            if (reg_hit(aw_addr, `ADCSQ_OFF_CTRL2)) begin
                converter_control_reg_two <= w_data[5:0];
            end
            if (reg_hit(aw_addr, `ADCSQ_OFF_CTRL)) begin
                enable <= w_data[`ADCSQ_EN_BIT];
            end
            if (reg_hit(aw_addr, `ADCSQ_OFF_MASK)) begin
                irq_mask <= w_data[`ADCSQ_IRQ_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Start/done bit
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_done <= 1'b0;
        end else if (go_set) begin
            go_done <= 1'b1;
        end else if (done_evt || go_clr || !enable) begin
            go_done <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flag and output
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_irq_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (done_evt) begin
                converter_irq_flag <= 1'b1;
            end else if (do_write && w_strb[0] && reg_hit(aw_addr, `ADCSQ_OFF_STATUS)
                && w_data[`ADCSQ_IRQ_BIT]) begin
                converter_irq_flag <= 1'b0;
            end
            irq <= (converter_irq_flag || done_evt) && irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // Comparator synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_sync <= 2'h0;
        end else begin
            comp_sync <= {comp_sync[0], comparator_in};
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= adcsq_pkg::ADCSQ_OFF;
            clk_cnt <= 4'h0;
            tad_cnt <= 5'h00;
            bit_idx <= 4'h0;
            dac_code <= 12'h000;
        end else if (!enable) begin
            state <= adcsq_pkg::ADCSQ_OFF;
            clk_cnt <= 4'h0;
        end else begin
            unique case (state)
                adcsq_pkg::ADCSQ_OFF: begin
                    state <= adcsq_pkg::ADCSQ_DISCHARGE;
                    clk_cnt <= 4'h0;
                end
                adcsq_pkg::ADCSQ_DISCHARGE: begin
                    if (clk_cnt == 4'(DISCHARGE_CLKS - 1)) begin
                        state <= adcsq_pkg::ADCSQ_SAMPLE;
                        clk_cnt <= 4'h0;
                    end else begin
                        clk_cnt <= clk_cnt + 4'h1;
                    end
                end
                adcsq_pkg::ADCSQ_SAMPLE: begin
                    clk_cnt <= 4'h0;
                    tad_cnt <= 5'h00;
                    if (go_done && acq_sel == 3'h0) begin
                        state <= adcsq_pkg::ADCSQ_START_WAIT;
                    end else if (go_done) begin
                        state <= adcsq_pkg::ADCSQ_ACQUIRE;
                    end
                end
                adcsq_pkg::ADCSQ_START_WAIT: begin
                    if (abort_evt) begin
                        state <= adcsq_pkg::ADCSQ_RECOVER;
                        clk_cnt <= 4'h0;
                    end else if (clk_cnt == WAIT_CLKS - 4'h1) begin
                        state <= adcsq_pkg::ADCSQ_CONVERT;
                        tad_cnt <= 5'h00;
                        bit_idx <= 4'hB;
                        dac_code <= 12'h800;
                    end else begin
                        clk_cnt <= clk_cnt + 4'h1;
                    end
                end
                adcsq_pkg::ADCSQ_ACQUIRE: begin
                    if (abort_evt) begin
                        state <= adcsq_pkg::ADCSQ_RECOVER;
                        clk_cnt <= 4'h0;
                    end else if (tad_bus.tick) begin
                        if (tad_cnt == acq_periods(acq_sel) - 5'h01) begin
                            state <= adcsq_pkg::ADCSQ_CONVERT;
                            tad_cnt <= 5'h00;
                            bit_idx <= 4'hB;
                            dac_code <= 12'h800;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                adcsq_pkg::ADCSQ_CONVERT: begin
                    if (abort_evt) begin
                        state <= adcsq_pkg::ADCSQ_RECOVER;
                        clk_cnt <= 4'h0;
                    end else if (done_evt) begin
                        state <= adcsq_pkg::ADCSQ_RECOVER;
                        clk_cnt <= 4'h0;
                    end else if (tad_bus.tick) begin
                        tad_cnt <= tad_cnt + 5'h01;
                        if (tad_cnt < 5'h0C) begin
                            dac_code[bit_idx] <= comp_sync[1];
                            if (bit_idx != 4'h0) begin
                                dac_code[bit_idx - 4'h1] <= 1'b1;
                                bit_idx <= bit_idx - 4'h1;
                            end
                        end
                    end
                end
                adcsq_pkg::ADCSQ_RECOVER: begin
                    if (clk_cnt == RECOVER_CLKS - 4'h1) begin
                        state <= adcsq_pkg::ADCSQ_DISCHARGE;
                        clk_cnt <= 4'h0;
                    end else begin
                        clk_cnt <= clk_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Result register pair and analog controls
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_register_pair <= 12'h000;
        end else if (done_evt && !go_clr) begin
            result_register_pair <= dac_code;
        end else if (do_write && reg_hit(aw_addr, `ADCSQ_OFF_RESULT)) begin
            if (w_strb[0]) begin
                result_register_pair[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                result_register_pair[11:8] <= w_data[11:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_en <= 1'b0;
            discharge_en <= 1'b0;
        end else begin
            sample_en <= enable && (state == adcsq_pkg::ADCSQ_SAMPLE
                || state == adcsq_pkg::ADCSQ_ACQUIRE);
            discharge_en <= enable && state == adcsq_pkg::ADCSQ_DISCHARGE;
        end
    end
endmodule // adcsq_seq
`default_nettype wire

// file: adcsq_seq_assertions.sv
// Purpose: Port assertions for the sequencer
// Assumes: Single aclk domain, reset active low
// Notes: Bound into adcsq_seq
`timescale 1ns/1ps
`default_nettype none
module adcsq_seq_chk #(
    parameter int DISCHARGE_CLKS = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic sample_en,
    input wire logic discharge_en,
    input wire logic irq
);
    int dcnt;
    // Length of the current discharge run
    always_ff @(posedge aclk) begin
        if (!aresetn || !discharge_en) dcnt <= 0;
        else dcnt <= dcnt + 1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_recover; !discharge_en [*8]; endsequence
    property p_reset_quiet; $rose(aresetn) |-> !irq && !sample_en && !discharge_en; endproperty
    property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_no_overlap; !(sample_en && discharge_en); endproperty
    property p_discharge_first; $rose(sample_en) |-> $past(discharge_en); endproperty
    property p_discharge_len; $fell(discharge_en) |-> dcnt == DISCHARGE_CLKS; endproperty
    property p_recovery; $rose(irq) |-> s_recover ##[1:3] discharge_en; endproperty
    property p_resume; $rose(irq) |-> ##[10:20] sample_en; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data not held");
    a_no_overlap: assert property (p_no_overlap) else $error("sample during discharge");
    a_discharge_first: assert property (p_discharge_first) else $error("no discharge");
    a_discharge_len: assert property (p_discharge_len) else $error("discharge length");
    a_recovery: assert property (p_recovery) else $error("recovery wait wrong");
    a_resume: assert property (p_resume) else $error("sampling not resumed");
endmodule // adcsq_seq_chk
bind adcsq_seq adcsq_seq_chk #(.DISCHARGE_CLKS(DISCHARGE_CLKS)) i_adcsq_seq_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .sample_en(sample_en),
    .discharge_en(discharge_en),
    .irq(irq)
);
`default_nettype wire

// file: adcsq_chan.sv
// Purpose: Analog channel and holding capacitor model
// Assumes: vin steady while sampled
// Notes: Held level sits half a step above vin, so no trial ties
`timescale 1ns/1ps
`default_nettype none
module adcsq_chan (
    input wire logic aclk,
    input wire logic sample_en,
    input wire logic discharge_en,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] vin,
    output logic comparator_in
);
    logic [12:0] held;
    always @(posedge aclk) begin
        if (discharge_en) held <= 13'h0;
        else if (sample_en) held <= {vin, 1'h1};
    end
    assign comparator_in = held > {dac_code, 1'h0};
endmodule // adcsq_chan
`default_nettype wire

// file: adcsq_seq_tb.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Channel model drives the comparator
// Notes: Read results are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
module adcsq_seq_tb;
    logic aclk = 0, aresetn = 0, rc_osc_in = 0, comparator_in, mask = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sample_en, discharge_en, irq;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, vin = 0, dac_code;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rs = 32'h4B;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] expq[$];
    int miscompares = 0, checks_done = 0, i;
    adcsq_seq i_adcsq_seq (.*);
    adcsq_chan i_adcsq_chan (.*);
    always #4 aclk = ~aclk;
    initial begin
        #0.5;
        forever #37 rc_osc_in = ~rc_osc_in;
    end
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1 && !ad) begin
                ad = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready === 1'h1 && !dd) begin
                dd = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1) @(posedge aclk);
        chk({32'h0, s_axi_bresp}, {32'h0, er});
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        expq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    end
    // One conversion; div 0 means the internal RC source
    task automatic conv(input logic [5:0] c2, input int div);
        int a, lo, na, n;
        na = c2[5:3] < 5 ? 2 * c2[5:3] : 4 * c2[5:3] - 8;
        vin <= 12'(xs());
        wr(`ADCSQ_OFF_CTRL2, {26'h0, c2});
        repeat (20) @(posedge aclk);
        wr(`ADCSQ_OFF_CTRL, 32'h3);
        for (a = 0; a < 3000 && sample_en; a++) @(posedge aclk);
        for (lo = 0; lo < 3000 && !discharge_en; lo++) @(posedge aclk);
        if (div > 0) begin
            chk(34'(a <= na * div + div + 4 && a + div + 4 >= na * div), 34'h1);
            n = 13 * div + 8 + (na == 0 ? 4 : 0);
            chk(34'(lo <= n + div + 4 && lo + div + 4 >= n), 34'h1);
        end
        if (div == 0 || div > 4) begin
            rd(`ADCSQ_OFF_RESULT, {22'h0, vin});
            chk({22'h0, dac_code}, {22'h0, vin});
        end
        rd(`ADCSQ_OFF_CTRL, 34'h1);
        rd(`ADCSQ_OFF_STATUS, 34'h1);
        chk({33'h0, irq}, {33'h0, mask});
        wr(`ADCSQ_OFF_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk({33'h0, irq}, 34'h0);
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ADCSQ_OFF_CTRL2, 34'h0);
        rd(12'h014, {2'h2, 32'h0});
        wr(12'h014, 32'h0, 2'h2);
        mask = 1;
        wr(`ADCSQ_OFF_MASK, 32'h1);
        wr(`ADCSQ_OFF_CTRL, 32'h1);
        repeat (250) @(posedge aclk);
        for (i = 0; i < 6; i++) conv({3'h0, i[0], i[2:1]}, 2 << i);
        conv(6'h03, 0);
        conv(6'h07, 0);
        for (i = 1; i < 8; i++) conv({i[2:0], 3'h1}, 8);
        mask = 0;
        wr(`ADCSQ_OFF_MASK, 32'h0);
        conv(6'h01, 8);
        wr(`ADCSQ_OFF_RESULT, 32'h5A5);
        wr(`ADCSQ_OFF_CTRL2, 32'h06);
        wr(`ADCSQ_OFF_CTRL, 32'h3);
        repeat (200) @(posedge aclk);
        wr(`ADCSQ_OFF_CTRL, 32'h1);
        repeat (40) @(posedge aclk);
        chk({33'h0, sample_en}, 34'h1);
        rd(`ADCSQ_OFF_RESULT, 34'h5A5);
        give_verdict();
    end
endmodule // adcsq_seq_tb
`default_nettype wire
